//--- core/config_guard.sv
`timescale 1ns/1ns
`default_nettype none
`include "fsafe_consts.svh"

module config_guard
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        safety_init_phase,
    input  wire logic [15:0] config_in,
    input  wire logic [21:0] upset_flip,
    output logic      [15:0] config_out,
    output logic             single_error_flag,
    output logic             double_error_detect
);
    import fsafe_pkg::*;

    guard_s r_reg;
    guard_s r_next;

    function automatic logic [21:0] encode(input logic [15:0] d);
        logic [21:0] w;
        int          k;
        w = '0;
        k = 0;
        for (int i = 1; i < 22; i++)
            if ((i & (i - 1)) != 0)
            begin
                w[i] = d[k];
                k++;
            end
        for (int p = 0; p < 5; p++)
            for (int i = 1; i < 22; i++)
                if (i[p] && ((i & (i - 1)) != 0))
                    w[1 << p] = w[1 << p] ^ w[i];
        w[0] = ^w[21:1];
        return w;
    endfunction

    function automatic logic [15:0] extract(input logic [21:0] w);
        logic [15:0] d;
        int          k;
        d = '0;
        k = 0;
        for (int i = 1; i < 22; i++)
            if ((i & (i - 1)) != 0)
            begin
                d[k] = w[i];
                k++;
            end
        return d;
    endfunction

    logic [4:0] syndrome;
    logic       parity;

    always_comb
    begin
        syndrome = '0;
        for (int i = 1; i < 22; i++)
            if (r_reg.word[i])
                syndrome = syndrome ^ 5'(i);
        parity = ^r_reg.word;
        r_next = r_reg;
        if (safety_init_phase)
            r_next.word = encode(config_in);
        else if (parity)
        begin
            // Odd parity means one flip: syndrome points at it
            r_next.word[syndrome] = ~r_reg.word[syndrome];
            r_next.single_seen = 1'b1;
        end
        else if (syndrome != 5'h0)
            r_next.double_seen = 1'b1;
        r_next.word = r_next.word ^ upset_flip;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_reg.word        <= encode(`CFG_RESET);
            r_reg.single_seen <= 1'b0;
            r_reg.double_seen <= 1'b0;
        end
        else
            r_reg <= r_next;
    end

    assign config_out          = extract(r_reg.word);
    assign single_error_flag   = r_reg.single_seen;
    assign double_error_detect = r_reg.double_seen;

endmodule
`default_nettype wire

//--- core/fail_safe_fault_output_control.sv
`timescale 1ns/1ns
`default_nettype none
`include "fsafe_consts.svh"

// How it works
// - Each new reset or output 0 counts
// - Watchdog error maximum counts while output 0 low
// - Threshold bit picks levels 3/6 or 1/2
// - Intermediate level asserts output 0 or reset
// - Final level with grounded strap: deep fail-safe
// - Reset low eight seconds: deep-safe or sleep
// - Configurable faults increment the fault count
// - Fixed fault list always increments the count
// - Start and wake: count one, output 0 low
// - Seven good answers take one off the count
// - Fixed causes always assert the reset output
// - Fixed causes always assert output 0
// - Init configuration gates other output 0 causes
// - Delay mode: output 1 follows after time
// - Duration mode: output 1 released after time
// - Backup switch open until MCU closes it
// - Release needs tests ok, count zero, key
// - Key bits 7:5 select which outputs release
// - Key low bits are inverted swapped random
// - Config free in init, then corrected
// - Double upset flags and asserts output 0
// - Refresh limit reached plus good answer decrements
// - Bad answer clears the refresh counter
module fail_safe_fault_output_control
#(
    parameter logic [15:0] CYCLES_PER_MS     = 16'(`CYCLES_PER_MS),
    parameter logic [12:0] RESET_LOW_LIMIT_MS = 13'(`RESET_LOW_LIMIT_MS)
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [11:0] fault_levels,
    input  wire logic        mcu_reset_sense,
    input  wire logic        deep_safe_strap,
    input  wire logic        safety_init_phase,
    input  wire logic        init_watchdog_fail,
    input  wire logic        watchdog_answer_good,
    input  wire logic        watchdog_answer_bad,
    input  wire logic        watchdog_error_max,
    input  wire logic        spi_reset_request,
    input  wire logic        spi_out0_request,
    input  wire logic        resume_from_low_power,
    input  wire logic        fault_threshold_select,
    input  wire logic [1:0]  fault_level_impact,
    input  wire logic [1:0]  watchdog_impact_select,
    input  wire logic [2:0]  watchdog_refresh_limit,
    input  wire logic [4:0]  out0_fault_mask,
    input  wire logic [2:0]  reset_fault_mask,
    input  wire logic [3:0]  second_output_time_code,
    input  wire logic        second_output_time_range,
    input  wire logic        second_output_duration_mode,
    input  wire logic        backup_switch_request,
    input  wire logic        analog_selftest_out1_ok,
    input  wire logic        analog_selftest_aux_ok,
    input  wire logic        aux_check_enabled,
    input  wire logic [7:0]  watchdog_random_word,
    input  wire logic [7:0]  release_key,
    input  wire logic        release_key_write,
    input  wire logic [21:0] upset_flip,
    output logic             mcu_reset_out_n,
    output logic             safe_out_zero_n,
    output logic             safe_out_one_n,
    output logic      [2:0]  fault_count,
    output logic             backup_switch_state,
    output logic             deep_fail_safe,
    output logic             low_power_off,
    output logic             single_error_flag,
    output logic             double_error_detect
);
    import fsafe_pkg::*;

    ctrl_s r_reg;
    ctrl_s r_next;

    logic [15:0] cfg;
    logic [15:0] cfg_in;

    // Config is sampled freely in init and frozen under check bits after
    assign cfg_in = {reset_fault_mask, out0_fault_mask, watchdog_refresh_limit,
                     watchdog_impact_select, fault_level_impact,
                     fault_threshold_select};

    config_guard guard
    (
        .clk_sys             (clk_sys),
        .rst_n               (rst_n),
        .safety_init_phase   (safety_init_phase),
        .config_in           (cfg_in),
        .upset_flip          (upset_flip),
        .config_out          (cfg),
        .single_error_flag   (single_error_flag),
        .double_error_detect (double_error_detect)
    );

    logic [13:0] rise;
    logic        tick;
    logic [2:0]  inter_level;
    logic [2:0]  final_level;
    logic        level_hit;
    logic        ded_rise;
    logic        always_inc;
    logic        out0_cause;
    logic        rst_cause;
    logic        new_out0;
    logic        new_rst;
    logic        inc;
    logic        dec;
    logic [11:0] out1_time;
    logic [4:0]  key0;
    logic [4:0]  key1;
    logic [4:0]  key_both;
    logic        fault_active;
    logic        ok_common;
    logic        rel0;
    logic        rel1;
    logic        rst_timeout;

    always_comb
    begin
        r_next = r_reg;

        // Two flops on every pin before any logic sees it
        r_next.pin_meta = {deep_safe_strap, mcu_reset_sense, fault_levels};
        r_next.pin_sync = r_reg.pin_meta;
        r_next.pin_prev = r_reg.pin_sync;
        rise = r_reg.pin_sync & ~r_reg.pin_prev;

        tick = (r_reg.tick_div == CYCLES_PER_MS - 16'h1);
        r_next.tick_div = tick ? 16'h0 : r_reg.tick_div + 16'h1;

        // Strap caught once, on the first millisecond after reset release
        if (!r_reg.strap_taken && tick)
        begin
            r_next.strap_taken = 1'b1;
            r_next.strap_grounded = ~r_reg.pin_sync[`PIN_STRAP];
        end

        if (cfg[`CFG_THRESH])
        begin
            inter_level = `INTER_LEVEL_NARROW;
            final_level = `FINAL_LEVEL_NARROW;
        end
        else
        begin
            inter_level = `INTER_LEVEL_WIDE;
            final_level = `FINAL_LEVEL_WIDE;
        end
        level_hit = (r_reg.fault_count >= inter_level);
        if (!level_hit)
            r_next.level_pulsed = 1'b0;

        r_next.ded_prev = double_error_detect;
        ded_rise = double_error_detect & ~r_reg.ded_prev;

        always_inc = rise[`PIN_PRE_OV] | rise[`PIN_COLLECTOR]
                   | rise[`PIN_ABIST] | rise[`PIN_RST_SHORT]
                   | rise[`PIN_EXT_RESET] | init_watchdog_fail
                   | ded_rise;

        out0_cause = rise[`PIN_PRE_OV] | rise[`PIN_ABIST] | rise[`PIN_LOGIC_SELFTEST]
                   | rise[`PIN_RST_SHORT] | rise[`PIN_OUT1_SHORT]
                   | init_watchdog_fail | spi_out0_request;
        out0_cause = out0_cause | ded_rise;
        out0_cause = out0_cause
                   | (|(rise[`PIN_COLLECTOR:`PIN_CORE]
                        & cfg[`CFG_OUT0_MASK +: 5]))
                   | (watchdog_error_max & cfg[`CFG_WD_IMP + 1]);
        out0_cause = out0_cause
                   | (level_hit & cfg[`CFG_LVL_IMP]);

        rst_cause = rise[`PIN_PRE_OV] | rise[`PIN_OUT0_SHORT]
                  | init_watchdog_fail | spi_reset_request;
        rst_cause = rst_cause
                  | (|(rise[`PIN_AUX:`PIN_CORE] & cfg[`CFG_RST_MASK +: 3]))
                  | (watchdog_error_max & cfg[`CFG_WD_IMP]);
        if (level_hit && cfg[`CFG_LVL_IMP + 1] && !r_reg.level_pulsed)
        begin
            rst_cause = 1'b1;
            r_next.level_pulsed = 1'b1;
        end

        new_out0 = out0_cause & ~r_reg.out0_low;
        new_rst = rst_cause & ~r_reg.rst_low;

        // One step per cycle at most; simultaneous causes count once
        inc = new_out0 | new_rst;
        inc = inc | (watchdog_error_max & r_reg.out0_low);
        inc = inc | always_inc
            | (|(rise[`PIN_EXT_IC:`PIN_CORE]
                 & cfg[`CFG_OUT0_MASK +: 4]));

        dec = 1'b0;
        if (watchdog_answer_bad)
            r_next.refresh_count = 3'h0;
        else if (watchdog_answer_good)
        begin
            if (r_reg.refresh_count >= cfg[`CFG_RFR_LIMIT +: 3])
            begin
                dec = 1'b1;
                r_next.refresh_count = 3'h0;
            end
            else
                r_next.refresh_count = r_reg.refresh_count + 3'h1;
        end

        if (inc)
        begin
            if (r_reg.fault_count < final_level)
                r_next.fault_count = r_reg.fault_count + 3'h1;
        end
        else if (dec && r_reg.fault_count != 3'h0)
            r_next.fault_count = r_reg.fault_count - 3'h1;

        // Reset pulse timed in milliseconds
        if (new_rst)
        begin
            r_next.rst_low = 1'b1;
            r_next.rst_pulse_ms = 4'h0;
        end
        else if (r_reg.rst_low && tick)
        begin
            if (r_reg.rst_pulse_ms == 4'(`RESET_PULSE_MS - 1))
                r_next.rst_low = 1'b0;
            else
                r_next.rst_pulse_ms = r_reg.rst_pulse_ms + 4'h1;
        end

        // Reset line watched at the pin, so an MCU hold counts too
        rst_timeout = 1'b0;
        if (r_reg.pin_sync[`PIN_RST_SENSE])
            r_next.rst_low_ms = 13'h0;
        else if (tick)
        begin
            if (r_reg.rst_low_ms >= RESET_LOW_LIMIT_MS - 13'h1)
                rst_timeout = 1'b1;
            else
                r_next.rst_low_ms = r_reg.rst_low_ms + 13'h1;
        end

        case (r_reg.mode)
            MODE_NORMAL:
            begin
                if (rst_timeout)
                    r_next.mode = r_reg.strap_grounded ? MODE_DEEP_SAFE
                                                       : MODE_SLEEP;
                else if (r_next.fault_count == final_level
                         && r_reg.strap_grounded)
                    r_next.mode = MODE_DEEP_SAFE;
            end
            MODE_DEEP_SAFE:
                r_next.mode = MODE_DEEP_SAFE;
            MODE_SLEEP:
            begin
                if (resume_from_low_power)
                    r_next.mode = MODE_NORMAL;
            end
            default:
                r_next.mode = MODE_NORMAL;
        endcase

        if (new_out0)
            r_next.out0_low = 1'b1;

        r_next.backup_closed = backup_switch_request;

        out1_time = second_output_time_range
                  ? 12'(second_output_time_code) * 12'(`TIME_STEP_LONG_MS)
                  : 12'(second_output_time_code) * 12'(`TIME_STEP_SHORT_MS);

        case (r_reg.out1_phase)
            OUT1_IDLE:
            begin
                if (new_out0)
                begin
                    r_next.out1_ms = 12'h0;
                    if (second_output_duration_mode)
                    begin
                        if (out1_time != 12'h0)
                        begin
                            r_next.out1_low = 1'b1;
                            r_next.out1_phase = OUT1_TIMED;
                        end
                    end
                    else if (out1_time == 12'h0)
                    begin
                        r_next.out1_low = 1'b1;
                        r_next.out1_phase = OUT1_HELD;
                    end
                    else
                        r_next.out1_phase = OUT1_WAIT;
                end
            end
            OUT1_WAIT:
            begin
                if (!r_reg.out0_low)
                    r_next.out1_phase = OUT1_IDLE;
                else if (tick)
                begin
                    if (r_reg.out1_ms >= out1_time - 12'h1)
                    begin
                        r_next.out1_low = 1'b1;
                        r_next.out1_phase = OUT1_HELD;
                    end
                    else
                        r_next.out1_ms = r_reg.out1_ms + 12'h1;
                end
            end
            OUT1_HELD:
                r_next.out1_phase = OUT1_HELD;
            OUT1_TIMED:
            begin
                if (tick)
                begin
                    if (r_reg.out1_ms >= out1_time - 12'h1)
                    begin
                        r_next.out1_low = 1'b0;
                        r_next.out1_phase = OUT1_IDLE;
                    end
                    else
                        r_next.out1_ms = r_reg.out1_ms + 12'h1;
                end
            end
            default:
            begin
                r_next.out1_phase = OUT1_IDLE;
                r_next.out1_low = 1'b0;
            end
        endcase

        // Expected key bits: random word inverted and bit order swapped
        key0 = ~{watchdog_random_word[0], watchdog_random_word[1],
                 watchdog_random_word[2], watchdog_random_word[3],
                 watchdog_random_word[4]};
        key1 = ~{watchdog_random_word[3], watchdog_random_word[4],
                 watchdog_random_word[5], watchdog_random_word[6],
                 watchdog_random_word[7]};
        key_both = ~{watchdog_random_word[0], watchdog_random_word[1],
                     watchdog_random_word[2], watchdog_random_word[6],
                     watchdog_random_word[7]};

        fault_active = |r_reg.pin_sync[`PIN_EXT_RESET:`PIN_PRE_OV];
        ok_common = release_key_write && !fault_active
                  && r_reg.fault_count == 3'h0
                  && (analog_selftest_aux_ok || !aux_check_enabled);
        rel0 = 1'b0;
        rel1 = 1'b0;
        if (ok_common)
        begin
            case (release_key[7:5])
                `KEY_OUT0:
                    rel0 = (release_key[4:0] == key0);
                `KEY_OUT1:
                    rel1 = (release_key[4:0] == key1)
                         && analog_selftest_out1_ok
                         && r_reg.backup_closed;
                `KEY_BOTH:
                begin
                    rel0 = (release_key[4:0] == key_both)
                         && analog_selftest_out1_ok
                         && r_reg.backup_closed;
                    rel1 = rel0;
                end
                default:
                begin
                    rel0 = 1'b0;
                    rel1 = 1'b0;
                end
            endcase
        end

        // A fresh cause in the release cycle keeps output 0 asserted; output 1 stays only when output 0 was high
        if (rel0 && !out0_cause)
            r_next.out0_low = 1'b0;
        if (rel1 && !new_out0)
        begin
            r_next.out1_low = 1'b0;
            r_next.out1_phase = OUT1_IDLE;
        end

        if (resume_from_low_power)
        begin
            r_next.fault_count = `FAULT_COUNT_RESET;
            r_next.out0_low = 1'b1;
            r_next.refresh_count = 3'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_reg                <= '0;
            r_reg.fault_count    <= `FAULT_COUNT_RESET;
            r_reg.out0_low       <= 1'b1;
            r_reg.out1_phase     <= OUT1_IDLE;
            r_reg.mode           <= MODE_NORMAL;
            r_reg.pin_meta       <= 14'h1000;
            r_reg.pin_sync       <= 14'h1000;
            r_reg.pin_prev       <= 14'h1000;
        end
        else
            r_reg <= r_next;
    end

    assign mcu_reset_out_n     = ~r_reg.rst_low;
    assign safe_out_zero_n     = ~r_reg.out0_low;
    assign safe_out_one_n      = ~r_reg.out1_low;
    assign fault_count         = r_reg.fault_count;
    assign backup_switch_state = r_reg.backup_closed;
    assign deep_fail_safe      = (r_reg.mode == MODE_DEEP_SAFE);
    assign low_power_off       = (r_reg.mode == MODE_SLEEP);

endmodule
`default_nettype wire

//--- core/fsafe_consts.svh
`ifndef FSAFE_CONSTS_SVH
`define FSAFE_CONSTS_SVH

// Clock and time base
`define CLK_HZ              50000000
`define CYCLES_PER_MS       (`CLK_HZ / 1000)
`define RESET_LOW_LIMIT_S   8
`define RESET_LOW_LIMIT_MS  (`RESET_LOW_LIMIT_S * 1000)
`define RESET_PULSE_MS      10
`define TIME_STEP_SHORT_MS  10
`define TIME_STEP_LONG_MS   210

// Fault count levels
`define FAULT_COUNT_RESET   3'h1
`define INTER_LEVEL_WIDE    3'h3
`define FINAL_LEVEL_WIDE    3'h6
`define INTER_LEVEL_NARROW  3'h1
`define FINAL_LEVEL_NARROW  3'h2

// Release key action codes, bits 7:5
`define KEY_OUT0            3'h3
`define KEY_OUT1            3'h6
`define KEY_BOTH            3'h5

// Protected configuration word layout
`define CFG_THRESH          0
`define CFG_LVL_IMP         1
`define CFG_WD_IMP          3
`define CFG_RFR_LIMIT       5
`define CFG_OUT0_MASK       8
`define CFG_RST_MASK        13
`define CFG_RESET           16'h1fc0

// Synchronised pin vector positions
`define PIN_PRE_OV          0
`define PIN_CORE            1
`define PIN_ANALOG          2
`define PIN_AUX             3
`define PIN_EXT_IC          4
`define PIN_COLLECTOR       5
`define PIN_ABIST           6
`define PIN_LOGIC_SELFTEST           7
`define PIN_RST_SHORT       8
`define PIN_OUT0_SHORT      9
`define PIN_OUT1_SHORT      10
`define PIN_EXT_RESET       11
`define PIN_RST_SENSE       12
`define PIN_STRAP           13

`endif

//--- core/fsafe_pkg.sv
`include "fsafe_consts.svh"

package fsafe_pkg;

    typedef enum logic [2:0] {
        MODE_NORMAL    = 3'b001,
        MODE_DEEP_SAFE = 3'b010,
        MODE_SLEEP     = 3'b100
    } power_mode_e;

    typedef enum logic [3:0] {
        OUT1_IDLE  = 4'b0001,
        OUT1_WAIT  = 4'b0010,
        OUT1_HELD  = 4'b0100,
        OUT1_TIMED = 4'b1000
    } out1_phase_e;

    typedef struct packed {
        logic [13:0] pin_meta;
        logic [13:0] pin_sync;
        logic [13:0] pin_prev;
        logic        strap_taken;
        logic        strap_grounded;
        logic [2:0]  fault_count;
        logic [2:0]  refresh_count;
        logic        out0_low;
        logic        out1_low;
        logic        rst_low;
        logic        level_pulsed;
        logic [3:0]  rst_pulse_ms;
        logic [15:0] tick_div;
        logic [12:0] rst_low_ms;
        logic [11:0] out1_ms;
        out1_phase_e out1_phase;
        power_mode_e mode;
        logic        backup_closed;
        logic        ded_prev;
    } ctrl_s;

    typedef struct packed {
        logic [21:0] word;
        logic        single_seen;
        logic        double_seen;
    } guard_s;

endpackage

//--- verif/fail_safe_fault_output_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module fail_safe_fault_output_control_tb;
    logic       clk_sys = 1'b0, rst_n = 1'b0, force_low = 1'b0;
    logic       safety_init_phase = 1'b1, backup_switch_request = 1'b0;
    logic       analog_selftest_out1_ok = 1'b1, analog_selftest_aux_ok = 1'b1;
    logic       deep_safe_strap = 1'b1, fault_threshold_select = 1'b0;
    logic [5:0] pls = 6'h0;
    logic [2:0] key_action = 3'h3;
    logic [7:0] watchdog_random_word = 8'hb6;
    logic [11:0] fault_levels = 12'h0;
    logic [4:0] out0_fault_mask = 5'h1f;
    logic [3:0] second_output_time_code = 4'h1;
    logic [2:0] watchdog_refresh_limit = 3'h6, reset_fault_mask = 3'h7;
    logic [1:0] fault_level_impact = 2'h0, watchdog_impact_select = 2'h0;
    logic init_watchdog_fail = 1'b0, aux_check_enabled = 1'b1;
    logic second_output_time_range = 1'b0;
    logic second_output_duration_mode = 1'b0;
    wire  [7:0] release_key;
    wire  [2:0] fault_count;
    wire        mcu_reset_out_n, safe_out_zero_n, safe_out_one_n;
    wire        backup_switch_state, deep_fail_safe, low_power_off;
    wire        mcu_reset_sense = mcu_reset_out_n & ~force_low;
    int         error_cnt = 0, total_checks = 0;
    always #10 clk_sys = ~clk_sys;
    fail_safe_fault_output_control
    #(.CYCLES_PER_MS(16'ha), .RESET_LOW_LIMIT_MS(13'h14)) DUT
    (
        .clk_sys, .rst_n, .fault_levels, .mcu_reset_sense, .deep_safe_strap,
        .safety_init_phase, .init_watchdog_fail, .watchdog_answer_good(pls[0]),
        .watchdog_answer_bad(pls[1]), .watchdog_error_max(pls[2]),
        .spi_reset_request(pls[3]), .spi_out0_request(pls[4]),
        .resume_from_low_power(1'b0), .fault_threshold_select,
        .fault_level_impact, .watchdog_impact_select, .watchdog_refresh_limit,
        .out0_fault_mask, .reset_fault_mask, .second_output_time_code,
        .second_output_time_range, .second_output_duration_mode,
        .backup_switch_request, .analog_selftest_out1_ok,
        .analog_selftest_aux_ok, .aux_check_enabled, .watchdog_random_word,
        .release_key, .release_key_write(pls[5]), .upset_flip(22'h0),
        .mcu_reset_out_n, .safe_out_zero_n, .safe_out_one_n, .fault_count,
        .backup_switch_state, .deep_fail_safe, .low_power_off,
        .single_error_flag(), .double_error_detect()
    );
    mcu_model u_mcu (.watchdog_random_word, .key_action, .release_key);
    task automatic check(input string what, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic pulse(input int i);
        step(1);
        pls[i] = 1'b1;
        step(1);
        pls[i] = 1'b0;
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic t_start;
        check("reset_out", mcu_reset_out_n, 8'h1);
        check("out0", safe_out_zero_n, 8'h0);
        check("count", fault_count, 8'h1);
        pulse(2);
        step(2);
        check("count", fault_count, 8'h2);
    endtask
    task automatic t_watchdog;
        repeat (7) pulse(0);
        step(2);
        check("count", fault_count, 8'h1);
        repeat (3) pulse(0);
        pulse(1);
        repeat (6) pulse(0);
        step(2);
        check("count", fault_count, 8'h1);
        pulse(0);
        step(2);
        check("count", fault_count, 8'h0);
    endtask
    task automatic t_release;
        // Random word is settled before each key is formed
        key_action = 3'h6;
        pulse(5);
        step(2);
        check("out0", safe_out_zero_n, 8'h0);
        key_action = 3'h3;
        pulse(5);
        step(2);
        check("out0", safe_out_zero_n, 8'h1);
    endtask
    task automatic t_pulses;
        pulse(3);
        step(2);
        check("reset_out", mcu_reset_out_n, 8'h0);
        check("count", fault_count, 8'h1);
        step(80);
        check("reset_out", mcu_reset_out_n, 8'h0);
        step(40);
        check("reset_out", mcu_reset_out_n, 8'h1);
        pulse(4);
        step(2);
        check("out0", safe_out_zero_n, 8'h0);
        check("count", fault_count, 8'h2);
        step(60);
        check("out1", safe_out_one_n, 8'h1);
        step(60);
        check("out1", safe_out_one_n, 8'h0);
        step(20);
        check("out1", safe_out_one_n, 8'h0);
    endtask
    task automatic t_limits;
        repeat (5)
        begin
            pulse(3);
            step(120);
        end
        check("count", fault_count, 8'h6);
        check("deep", deep_fail_safe, 8'h0);
        force_low = 1'b1;
        step(240);
        check("sleep", low_power_off, 8'h1);
        check("deep", deep_fail_safe, 8'h0);
    endtask
    initial
    begin
        step(20);
        rst_n = 1'b1;
        step(3);
        safety_init_phase = 1'b0;
        t_start;
        t_watchdog;
        t_release;
        t_pulses;
        t_limits;
        close_out;
    end
    initial
    begin
        #200000;
        error_cnt++;
        close_out;
    end
endmodule
`default_nettype wire

//--- verif/fsafe_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module fsafe_monitor
(
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       spi_reset_request,
    input wire logic       spi_out0_request,
    input wire logic       watchdog_error_max,
    input wire logic       backup_switch_request,
    input wire logic       second_output_duration_mode,
    input wire logic       mcu_reset_out_n,
    input wire logic       safe_out_zero_n,
    input wire logic       safe_out_one_n,
    input wire logic [2:0] fault_count,
    input wire logic       backup_switch_state
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence s_rst_held;
        !mcu_reset_out_n [*8];
    endsequence
    property p_spi_rst;
        spi_reset_request |=> s_rst_held;
    endproperty
    property p_cnt_inc;
        spi_reset_request && fault_count == 3'h0 |=> fault_count == 3'h1;
    endproperty
    property p_sat;
        fault_count <= 3'h6;
    endproperty
    property p_out0_req;
        spi_out0_request |=> !safe_out_zero_n;
    endproperty
    property p_wd_max;
        watchdog_error_max && !safe_out_zero_n && fault_count == 3'h1
            |=> fault_count == 3'h2;
    endproperty
    property p_hold_out0;
        fault_count != 3'h0 && !safe_out_zero_n |=> !safe_out_zero_n;
    endproperty
    property p_backup;
        backup_switch_request |=> backup_switch_state;
    endproperty
    property p_out1_hold;
        !safe_out_one_n && !backup_switch_state && !second_output_duration_mode
            |=> !safe_out_one_n;
    endproperty
    a_spi_rst: assert property (p_spi_rst) else $error("reset short");
    a_cnt_inc: assert property (p_cnt_inc) else $error("no count");
    a_sat: assert property (p_sat) else $error("count high");
    a_out0_req: assert property (p_out0_req) else $error("out0 idle");
    a_wd_max: assert property (p_wd_max) else $error("wd max");
    a_hold_out0: assert property (p_hold_out0) else $error("early");
    a_backup: assert property (p_backup) else $error("switch");
    a_out1_hold: assert property (p_out1_hold) else $error("out1");
endmodule
bind fail_safe_fault_output_control fsafe_monitor u_mon (.*);
`default_nettype wire

//--- verif/mcu_model.sv
`timescale 1ns/1ns
`default_nettype none
module mcu_model
(
    input  wire logic [7:0] watchdog_random_word,
    input  wire logic [2:0] key_action,
    output logic      [7:0] release_key
);
    logic [7:0] flipped;
    always_comb
    begin
        // Swapped and inverted, so a stuck bus never forms a key
        for (int i = 0; i < 8; i++)
            flipped[7 - i] = ~watchdog_random_word[i];
        case (key_action)
            3'h3:    release_key = {key_action, flipped[7:3]};
            3'h6:    release_key = {key_action, flipped[4:0]};
            default: release_key = {key_action, flipped[7:5], flipped[1:0]};
        endcase
    end
endmodule
`default_nettype wire
